// file: wdt_defs.svh
// Constants for the watchdog timer unit: register offsets, fields, codes.
// Assumes inclusion by bare name from any file of the unit.
`ifndef WDT_DEFS_SVH
`define WDT_DEFS_SVH
`define WDT_OFF_MODE      12'h000
`define WDT_OFF_KEY       12'h004
`define WDT_OFF_STATUS    12'h008
`define WDT_OFF_MASK      12'h00C
`define WDT_BIT_EN        7
`define WDT_BIT_PLO       4
`define WDT_BIT_PHI       6
`define WDT_BIT_IDLE      2
`define WDT_BIT_ACT       1
`define WDT_MODE_RST      8'h82
`define WDT_MODE_WMASK    8'hF6
`define WDT_CODE_DIS      8'hB1
`define WDT_CODE_CLR      8'h4E
`define WDT_PER_BASE      5'd15
`define WDT_PER_MAX       3'b101
`define WDT_RST_STATES    6'd32
`define WDT_RESP_OKAY     2'b00
`define WDT_RESP_SLVERR   2'b10
`endif

// file: wdt_pkg.sv
// Types shared by the watchdog timer unit.
// Assumes wdt_defs.svh constants alongside.
`default_nettype none
package wdt_pkg;
   typedef struct packed {
      logic       en;
      logic [2:0] period;
      logic       idle_run;
      logic       act_reset;
   } wdt_cfg_s;
   typedef enum logic [1:0] {
      WDT_RUN   = 2'b00,
      WDT_FIRED = 2'b01,
      WDT_RESET = 2'b10
   } wdt_state_e;
endpackage : wdt_pkg
`default_nettype wire

// file: wdt_counter.sv
// Watchdog binary up-counter with period-select overflow detect.
// Assumes single clock; advance and clear come from same-domain logic.
`default_nettype none
`include "wdt_defs.svh"
module wdt_counter #(
   parameter int CW = 26
) (
   // Clock and reset
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic       ce,
   // Control
   input  wire logic       advance,
   input  wire logic       clear,
   input  wire logic [2:0] period,
   // Result
   output logic            overflow,
   output logic [CW-1:0]   count
);
   // Period select to cycle count exponent
   function automatic logic [4:0] wdt_exp(input logic [2:0] p);
      wdt_exp = `WDT_PER_BASE + {1'b0, p, 1'b0};
   endfunction : wdt_exp

   logic [CW-1:0] limit;
   assign limit = CW'(1) << wdt_exp(period);

   // Count; clear wins over advance
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count <= '0;
      end else if (ce) begin
         if (clear) begin
            count <= '0;
         end else if (advance && !overflow) begin
            count <= count + CW'(1);
         end
      end
   end

   // Overflow when selected period is reached
   assign overflow = (count >= limit) && (period <= `WDT_PER_MAX);
endmodule : wdt_counter
`default_nettype wire

// file: wdt_rst_stretch.sv
// Holds the internal reset request for a fixed number of states.
// Assumes a one-cycle trigger from same-domain logic.
`default_nettype none
`include "wdt_defs.svh"
module wdt_rst_stretch (
   // Clock and reset
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic ce,
   // Trigger and output
   input  wire logic trigger,
   output logic      rst_req
);
   logic [5:0] left_r;
   // Load on trigger, count down
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         left_r <= '0;
      end else if (ce) begin
         if (trigger) begin
            left_r <= `WDT_RST_STATES;
         end else if (left_r != '0) begin
            left_r <= left_r - 6'd1;
         end
      end
   end
   assign rst_req = (left_r != '0);
endmodule : wdt_rst_stretch
`default_nettype wire

// file: wdt_top.sv
// Watchdog timer unit with AXI4-Lite register slave.
// Assumes one 100 MHz clock, synchronous active-low reset; debug and idle
// indications arrive from pins and are synchronised here.
`default_nettype none
`include "wdt_defs.svh"
// Overview of operation
// - Counter advances each clock while enabled
// - Six power-of-two detection periods selectable
// - Encodings 000..101 valid, 110/111 reserved
// - Overflow with action 0 raises NMI
// - Action 1 asserts internal reset 32 states
// - Action select resets to one
// - Fault output low with interrupt, clear releases
// - Counting starts right after reset release
// - Clear code zeroes counter, counting resumes
// - Disable code works only if enable 0
// - Enable bit resets one, write enables
// - Key register 8-bit write-only, reads zero
// - Idle stops counter unless idle run set
// - Debug mode freezes counter
module wdt_top (
   // Clock, reset, enable
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        ce,
   // AXI4-Lite write address
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // AXI4-Lite read address
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Chip status pins
   input  wire logic        debug_mode,
   input  wire logic        idle_mode,
   // Watchdog outputs
   output logic             overflow_interrupt,
   output logic             wdt_reset_req,
   output logic             fault_out_n,
   output logic             irq
);
   wdt_pkg::wdt_cfg_s   cfg_r;
   wdt_pkg::wdt_state_e state_r;
   logic [1:0]  dbg_sync_r, idle_sync_r;
   logic [11:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0]  wstrb_r;
   logic        aw_have_r, w_have_r;
   logic        wr_go, wr_hit_mode, wr_hit_key, wr_hit_mask;
   logic [7:0]  key_byte;
   logic        key_clear, key_disable;
   logic        advance, overflow, fire, rst_trig;
   logic [25:0] count;
   logic [1:0]  status_r, mask_r;
   logic        rd_status;

   // Two-flop synchronisers for chip status pins
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dbg_sync_r  <= '0;
         idle_sync_r <= '0;
      end else if (ce) begin
         dbg_sync_r  <= {dbg_sync_r[0], debug_mode};
         idle_sync_r <= {idle_sync_r[0], idle_mode};
      end
   end

   // Write channel capture; address and data in either order
   assign s_axi_awready = !aw_have_r && !s_axi_bvalid;
   assign s_axi_wready  = !w_have_r && !s_axi_bvalid;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_r <= 1'b0;
         w_have_r  <= 1'b0;
         awaddr_r  <= '0;
         wdata_r   <= '0;
         wstrb_r   <= '0;
      end else if (ce) begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_r <= 1'b1;
            awaddr_r  <= s_axi_awaddr;
         end else if (wr_go) begin
            aw_have_r <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_r <= 1'b1;
            wdata_r  <= s_axi_wdata;
            wstrb_r  <= s_axi_wstrb;
         end else if (wr_go) begin
            w_have_r <= 1'b0;
         end
      end
   end

   // Write decode
   assign wr_go       = aw_have_r && w_have_r;
   assign wr_hit_mode = wr_go && awaddr_r[11:2] == `WDT_OFF_MODE >> 2 && wstrb_r[0];
   assign wr_hit_key  = wr_go && awaddr_r[11:2] == `WDT_OFF_KEY >> 2 && wstrb_r[0];
   assign wr_hit_mask = wr_go && awaddr_r[11:2] == `WDT_OFF_MASK >> 2 && wstrb_r[0];
   assign key_byte    = wdata_r[7:0];
   assign key_clear   = wr_hit_key && key_byte == `WDT_CODE_CLR;
   assign key_disable = wr_hit_key && key_byte == `WDT_CODE_DIS && !cfg_r.en;

   // Write response; unmapped address gets SLVERR
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `WDT_RESP_OKAY;
      end else if (ce) begin
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (awaddr_r[11:2] <= `WDT_OFF_MASK >> 2) ?
                            `WDT_RESP_OKAY : `WDT_RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Mode register; enable and action reset to one
   localparam logic [7:0] MODE_RST = `WDT_MODE_RST;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cfg_r <= wdt_pkg::wdt_cfg_s'({MODE_RST[`WDT_BIT_EN],
                  MODE_RST[`WDT_BIT_PHI:`WDT_BIT_PLO],
                  MODE_RST[`WDT_BIT_IDLE], MODE_RST[`WDT_BIT_ACT]});
      end else if (ce && wr_hit_mode) begin
         cfg_r.en        <= wdata_r[`WDT_BIT_EN];
         cfg_r.period    <= wdata_r[`WDT_BIT_PHI:`WDT_BIT_PLO];
         cfg_r.idle_run  <= wdata_r[`WDT_BIT_IDLE];
         cfg_r.act_reset <= wdata_r[`WDT_BIT_ACT];
      end
   end

   // Running state: disabled only by key after enable cleared
   logic running_r;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         running_r <= 1'b1;
      end else if (ce) begin
         if (key_disable) begin
            running_r <= 1'b0;
         end else if (wr_hit_mode && wdata_r[`WDT_BIT_EN]) begin
            running_r <= 1'b1;
         end
      end
   end

   // Counter advance gating
   assign advance = running_r && !dbg_sync_r[1] &&
                    !(idle_sync_r[1] && !cfg_r.idle_run);

   wdt_counter #(
      .CW (26)
   ) u_counter (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .ce       (ce),
      .advance  (advance),
      .clear    (key_clear || key_disable || !running_r),
      .period   (cfg_r.period),
      .overflow (overflow),
      .count    (count)
   );

   // Detection state machine
   assign fire     = overflow && running_r && state_r == wdt_pkg::WDT_RUN;
   assign rst_trig = fire && cfg_r.act_reset;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_r <= wdt_pkg::WDT_RUN;
      end else if (ce) begin
         case (state_r)
            wdt_pkg::WDT_RUN: begin
               if (fire) begin
                  state_r <= cfg_r.act_reset ? wdt_pkg::WDT_RESET : wdt_pkg::WDT_FIRED;
               end
            end
            wdt_pkg::WDT_FIRED: begin
               if (key_clear || key_disable) begin
                  state_r <= wdt_pkg::WDT_RUN;
               end
            end
            wdt_pkg::WDT_RESET: begin
               if (key_clear || key_disable) begin
                  state_r <= wdt_pkg::WDT_RUN;
               end
            end
            default: begin
               state_r <= wdt_pkg::WDT_RUN;
            end
         endcase
      end
   end

   // Interrupt and fault pin
   assign overflow_interrupt = state_r == wdt_pkg::WDT_FIRED;
   assign fault_out_n        = !(state_r != wdt_pkg::WDT_RUN);

   wdt_rst_stretch u_rst (
      .aclk    (aclk),
      .aresetn (aresetn),
      .ce      (ce),
      .trigger (rst_trig),
      .rst_req (wdt_reset_req)
   );

   // Sticky status: bit0 interrupt, bit1 reset; set beats read clear
   assign rd_status = s_axi_arvalid && s_axi_arready &&
                      s_axi_araddr[11:2] == `WDT_OFF_STATUS >> 2;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         status_r <= '0;
         mask_r   <= '0;
      end else if (ce) begin
         status_r <= (rd_status ? 2'b00 : status_r) |
                     {rst_trig, fire && !cfg_r.act_reset};
         if (wr_hit_mask) begin
            mask_r <= wdata_r[1:0];
         end
      end
   end
   assign irq = |(status_r & mask_r);

   // Read channel
   assign s_axi_arready = !s_axi_rvalid;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= '0;
         s_axi_rresp  <= `WDT_RESP_OKAY;
      end else if (ce) begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `WDT_RESP_OKAY;
            case (s_axi_araddr[11:2])
               `WDT_OFF_MODE >> 2: begin
                  s_axi_rdata <= {24'h0000_00, cfg_r.en, cfg_r.period, 1'b0,
                                  cfg_r.idle_run, cfg_r.act_reset, 1'b0};
               end
               `WDT_OFF_KEY >> 2: begin
                  s_axi_rdata <= 32'h0000_0000;
               end
               `WDT_OFF_STATUS >> 2: begin
                  s_axi_rdata <= {30'h0000_0000, status_r};
               end
               `WDT_OFF_MASK >> 2: begin
                  s_axi_rdata <= {30'h0000_0000, mask_r};
               end
               default: begin
                  s_axi_rdata <= 32'h0000_0000;
                  s_axi_rresp <= `WDT_RESP_SLVERR;
               end
            endcase
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // Checks
   int unsigned hold_cnt;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hold_cnt <= 0;
      end else if (ce) begin
         hold_cnt <= wdt_reset_req ? hold_cnt + 1 : 0;
      end
   end
   rst_len_a: assert property (@(posedge aclk) disable iff (!aresetn)
      hold_cnt <= 32) else $error("reset held too long");
   nmi_sel_a: assert property (@(posedge aclk) disable iff (!aresetn)
      ce && fire && !cfg_r.act_reset |=> overflow_interrupt) else $error("no nmi");
   rst_sel_a: assert property (@(posedge aclk) disable iff (!aresetn)
      ce && rst_trig |=> wdt_reset_req [*8]) else $error("no reset");
   fault_a: assert property (@(posedge aclk) disable iff (!aresetn)
      overflow_interrupt |-> !fault_out_n) else $error("fault not low");
   clr_a: assert property (@(posedge aclk) disable iff (!aresetn)
      ce && key_clear |=> count == 0) else $error("clear failed");
   dis_a: assert property (@(posedge aclk) disable iff (!aresetn)
      ce && wr_hit_key && cfg_r.en && running_r |=> running_r)
      else $error("disabled while enabled");
   dbg_a: assert property (@(posedge aclk) disable iff (!aresetn)
      ce && dbg_sync_r[1] && !key_clear && !key_disable && running_r |=> $stable(count))
      else $error("count moved in debug");
   off_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !running_r |-> !overflow_interrupt && count == 0 && fault_out_n)
      else $error("event while disabled");
endmodule : wdt_top
`default_nettype wire

// file: testbench.sv
// Self-checking bench for the watchdog timer unit: register bus, overflow
// actions, key codes, freeze inputs. Assumes wdt_top and its header alongside.
`default_nettype none
`include "wdt_defs.svh"
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin mismatches++; \
   $display("BAD %s exp %h got %h", nm, exp, got); end end
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int P0    = 32768;
   localparam int TOL   = 16;
   localparam int LIMIT = 104000;
   logic        aclk, aresetn, ce, debug_mode, idle_mode;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready;
   logic        overflow_interrupt, wdt_reset_req, fault_out_n, irq;
   int          mismatches, tests_run, cyc, t0, n;
   logic [1:0]  resp;
   logic [31:0] rd;
   wdt_top DUT (
      .aclk(aclk), .aresetn(aresetn), .ce(ce),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .debug_mode(debug_mode), .idle_mode(idle_mode),
      .overflow_interrupt(overflow_interrupt), .wdt_reset_req(wdt_reset_req),
      .fault_out_n(fault_out_n), .irq(irq)
   );
   // Clock generator
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   // Cycle count and hang guard
   always @(posedge aclk) begin
      cyc++;
      if (cyc > LIMIT) begin
         mismatches++;
         summarize();
      end
   end
   task automatic summarize();
      if (mismatches == 0 && tests_run > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : summarize
   // Bus write: address and data offered together, each released when taken
   task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
      bit aw_done;
      bit w_done;
      aw_done = 0;
      w_done = 0;
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(aw_done && w_done)) begin
         @(posedge aclk);
         if (!aw_done && s_axi_awready === 1'b1) begin
            aw_done = 1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w_done && s_axi_wready === 1'b1) begin
            w_done = 1;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
      @(posedge aclk);
   endtask : axi_wr
   // Bus read returning data and response
   task automatic axi_rd(input logic [11:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
      rd = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   endtask : axi_rd
   // Read and compare data and response
   task automatic chk_rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r,
                         input string nm);
      axi_rd(a);
      `CHK(nm, d, rd)
      `CHK(nm, r, resp)
   endtask : chk_rd
   // Wait for an event; its delay from t0 must lie within tolerance
   task automatic wait_evt(input bit sel, input int want, input string nm);
      int got;
      while ((sel ? overflow_interrupt : wdt_reset_req) !== 1'b1 && cyc < t0 + want + TOL)
         @(posedge aclk);
      got = cyc - t0;
      if (got >= want - TOL && got <= want + TOL) got = want;
      `CHK(nm, want, got)
   endtask : wait_evt
   // Reset values, key reads, unmapped place, reset action on overflow
   task automatic s_reset();
      chk_rd(`WDT_OFF_MODE, 32'h0000_0082, 2'b00, "mode_rst");
      chk_rd(`WDT_OFF_KEY, 32'h0000_0000, 2'b00, "key_rd");
      chk_rd(12'h010, 32'h0000_0000, 2'b10, "unmapped");
      wait_evt(1'b0, P0, "rst_time");
      `CHK("fault_rst", 1'b0, fault_out_n)
      `CHK("nmi_rst", 1'b0, overflow_interrupt)
      n = 0;
      while (wdt_reset_req === 1'b1 && n < 100) begin
         n++;
         @(posedge aclk);
      end
      `CHK("rst_len", 32, n)
      `CHK("irq_masked", 1'b0, irq)
      chk_rd(`WDT_OFF_STATUS, 32'h0000_0002, 2'b00, "stat_rst");
      chk_rd(`WDT_OFF_STATUS, 32'h0000_0000, 2'b00, "stat_clr");
   endtask : s_reset
   // Interrupt action; idle with run bit; reserved and early disable codes ignored
   task automatic s_nmi();
      axi_wr(`WDT_OFF_MODE, 32'h0000_0084);
      axi_wr(`WDT_OFF_MASK, 32'h0000_0001);
      axi_wr(`WDT_OFF_KEY, 32'h0000_004E);
      t0 = cyc;
      `CHK("fault_clr", 1'b1, fault_out_n)
      idle_mode <= 1'b1;
      repeat (16000) @(posedge aclk);
      axi_wr(`WDT_OFF_KEY, 32'h0000_0055);
      axi_wr(`WDT_OFF_KEY, 32'h0000_00B1);
      `CHK("fault_rsv", 1'b1, fault_out_n)
      wait_evt(1'b1, P0, "nmi_time");
      @(posedge aclk);
      `CHK("fault_nmi", 1'b0, fault_out_n)
      `CHK("rst_nmi", 1'b0, wdt_reset_req)
      `CHK("irq_on", 1'b1, irq)
      chk_rd(`WDT_OFF_STATUS, 32'h0000_0001, 2'b00, "stat_nmi");
      `CHK("irq_off", 1'b0, irq)
      axi_wr(`WDT_OFF_KEY, 32'h0000_004E);
      `CHK("nmi_end", 1'b0, overflow_interrupt)
      `CHK("fault_end", 1'b1, fault_out_n)
      idle_mode <= 1'b0;
   endtask : s_nmi
   // Writable bits, disable sequence, re-enable, debug and idle freezes
   task automatic s_disable();
      axi_wr(`WDT_OFF_MODE, 32'h0000_00FF);
      chk_rd(`WDT_OFF_MODE, 32'h0000_00F6, 2'b00, "mode_wr");
      axi_wr(`WDT_OFF_MODE, 32'h0000_0000);
      axi_wr(`WDT_OFF_KEY, 32'h0000_00B1);
      repeat (200) @(posedge aclk);
      `CHK("dis_nmi", 1'b0, overflow_interrupt)
      `CHK("dis_fault", 1'b1, fault_out_n)
      axi_wr(`WDT_OFF_MODE, 32'h0000_0080);
      t0 = cyc;
      debug_mode <= 1'b1;
      repeat (1000) @(posedge aclk);
      debug_mode <= 1'b0;
      idle_mode <= 1'b1;
      repeat (1000) @(posedge aclk);
      idle_mode <= 1'b0;
      wait_evt(1'b1, P0 + 2000, "frz_time");
   endtask : s_disable
   // Main sequence
   initial begin
      mismatches = 0;
      tests_run = 0;
      cyc = 0;
      aresetn = 1'b0;
      ce = 1'b1;
      debug_mode = 1'b0;
      idle_mode = 1'b0;
      s_axi_awaddr = '0;
      s_axi_awvalid = 1'b0;
      s_axi_wdata = '0;
      s_axi_wstrb = 4'hF;
      s_axi_wvalid = 1'b0;
      s_axi_bready = 1'b0;
      s_axi_araddr = '0;
      s_axi_arvalid = 1'b0;
      s_axi_rready = 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      t0 = cyc;
      s_reset();
      s_nmi();
      s_disable();
      summarize();
   end
endmodule : testbench
`default_nettype wire
